// [core/arsq_pkg.sv]
package arsq_pkg;
  // Setting grid and clock
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TIME_STEP_NS  = 5000000;
  localparam int unsigned TICK_CYCLES   = TIME_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned TIME_W        = 19;
  localparam logic [18:0] MAX_STEPS     = 19'h57e40;  // 1800.000 s in 5 ms steps
  localparam int unsigned NUM_SHOTS     = 5;

  // Register offsets
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_GRECL    = 12'h004;
  localparam logic [11:0] ADDR_STATUS   = 12'h008;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;
  localparam logic [5:0]  CH_BASE_IDX   = 6'h01;  // channel n at 0x40*(n+1)
  localparam logic [3:0]  WORD_ENABLE   = 4'h0;
  localparam logic [3:0]  WORD_DEAD0    = 4'h1;
  localparam logic [3:0]  WORD_RECL0    = 4'h6;

  // Field positions
  localparam int unsigned CTRL_WIN_EN   = 0;
  localparam int unsigned CTRL_FT_RET   = 1;
  localparam int unsigned IRQ_W         = 4;
  localparam int unsigned IRQ_START     = 0;
  localparam int unsigned IRQ_CLOSE     = 1;
  localparam int unsigned IRQ_SUCCESS   = 2;
  localparam int unsigned IRQ_LOCK      = 3;

  // Values after reset
  localparam logic [1:0]  CTRL_RST      = 2'h1;
  localparam logic [18:0] GRECL_RST     = 19'h007d0;  // 10 s
  localparam logic [4:0]  SHOT_EN_RST   = 5'h03;
  localparam logic [18:0] DEAD1_RST     = 19'h00028;  // 200 ms
  localparam logic [18:0] DEADN_RST     = 19'h02ee0;  // 60 s
  localparam logic [18:0] RECL_RST      = 19'h007d0;  // 10 s

  typedef enum logic [2:0] {
    ST_READY, ST_WAIT_OPEN, ST_DEAD, ST_CLOSE_REQ,
    ST_SHOT_RECLAIM, ST_GLOBAL_RECLAIM, ST_FINAL_TRIP, ST_LOCKOUT
  } arsq_state_t;
endpackage : arsq_pkg

// [core/arsq_sequencer.sv]
`timescale 1ns/1ps
module arsq_sequencer #(
  parameter int unsigned NUM_CH      = 2,
  parameter int unsigned TICK_CYCLES = arsq_pkg::TICK_CYCLES
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic [NUM_CH-1:0] trip_request,
  input  wire logic              breaker_open,
  input  wire logic              breaker_closed,
  input  wire logic              breaker_fail,
  input  wire logic              lockout_reset,
  output logic                   close_request,
  output logic                   reclose_cycle_active,
  output logic [NUM_CH-1:0]      channel_pending,
  output logic [4:0]             shot_active,
  output logic                   global_recovery_window,
  output logic                   final_trip,
  output logic                   reclose_blocked_state,
  output logic                   irq
);
  localparam int unsigned CW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
  localparam int unsigned TW = arsq_pkg::TIME_W;

  // Channel index must fit the six address bits above each table
  if (NUM_CH < 2 || NUM_CH > 62)
  begin : g_bad_ch
    $error("NUM_CH must be 2..62");
  end

  // Setting storage, one table per request channel
  logic [4:0]    shot_en [NUM_CH];
  logic [TW-1:0] dead_t  [NUM_CH][5];
  logic [TW-1:0] recl_t  [NUM_CH][5];
  logic [1:0]    ctrl;
  logic [TW-1:0] grecl_t;
  logic [arsq_pkg::IRQ_W-1:0] irq_stat;
  logic [arsq_pkg::IRQ_W-1:0] irq_mask;
  logic [arsq_pkg::IRQ_W-1:0] irq_ev;

  arsq_pkg::arsq_state_t state;
  logic [CW-1:0]     act_ch;
  logic [2:0]        shot;
  logic [NUM_CH-1:0] trip_q;
  logic              closed_q;
  logic              timer_start;
  logic [TW-1:0]     timer_steps;
  logic              timer_done;

  // Bus data phase bookkeeping
  logic        wr_pend;
  logic [11:0] wr_addr;
  logic        acc;
  logic        rd_clr;
  logic [31:0] rd_val;
  logic [CW-1:0] wr_ch;
  logic [3:0]    wr_word;
  logic          wr_ch_ok;

  // Trip and channel selection
  logic              any_trip;
  logic [CW-1:0]     new_ch;
  logic              act_trip;
  logic              act_rise;
  logic              closed_rise;
  logic [2:0]        find_from;
  logic [CW-1:0]     find_ch;
  logic              nxt_found;
  logic [2:0]        nxt_idx;
  logic              tmr_fire;

  assign acc      = hsel && htrans[1] && hready;
  assign wr_ch    = CW'(wr_addr[11:6] - arsq_pkg::CH_BASE_IDX);
  assign wr_word  = wr_addr[5:2];
  assign wr_ch_ok = (wr_addr[11:6] >= arsq_pkg::CH_BASE_IDX) &&
                    (32'(wr_addr[11:6]) < NUM_CH + 1);
  assign any_trip = |trip_request;
  assign act_trip = trip_request[act_ch];
  assign act_rise = trip_request[act_ch] && !trip_q[act_ch];
  assign closed_rise = breaker_closed && !closed_q;

  // A done pulse from an interval cut short must not end the one just started
  assign tmr_fire    = timer_done && !timer_start;

  // Lowest requesting channel wins when several trip at once
  always_comb
  begin
    new_ch = '0;
    for (int c = NUM_CH - 1; c >= 0; c--)
      if (trip_request[c])
        new_ch = CW'(c);
  end

  // Shot search uses the starting channel's table
  assign find_ch   = (state == arsq_pkg::ST_READY) ? new_ch : act_ch;
  assign find_from = (state == arsq_pkg::ST_READY) ? 3'h0 : shot + 3'h1;

  arsq_shot_find u_find (
    .shot_en (shot_en[find_ch]),
    .from    (find_from),
    .found   (nxt_found),
    .idx     (nxt_idx)
  );

  arsq_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (timer_start),
    .steps   (timer_steps),
    .done    (timer_done)
  );

  // Edge history for renewed trips and breaker closing
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      trip_q   <= '0;
      closed_q <= 1'b1;  // A rise counts only after the breaker was seen open
    end
    else
    begin
      trip_q   <= trip_request;
      closed_q <= breaker_closed;
    end

  // Reclosing sequence and its flags
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      state                  <= arsq_pkg::ST_READY;
      act_ch                 <= '0;
      shot                   <= 3'h0;
      close_request          <= 1'b0;
      reclose_cycle_active   <= 1'b0;
      channel_pending        <= '0;
      shot_active            <= 5'h00;
      global_recovery_window <= 1'b0;
      final_trip             <= 1'b0;
      reclose_blocked_state  <= 1'b0;
      timer_start            <= 1'b0;
      timer_steps            <= '0;
    end
    else
    begin
      timer_start <= 1'b0;
      final_trip  <= 1'b0;
      case (state)
        arsq_pkg::ST_READY:
          if (any_trip && nxt_found)
          begin
            state                <= arsq_pkg::ST_WAIT_OPEN;
            act_ch               <= new_ch;
            shot                 <= nxt_idx;
            reclose_cycle_active <= 1'b1;
            channel_pending      <= NUM_CH'(1) << new_ch;
            shot_active          <= 5'h01 << nxt_idx;
          end
        arsq_pkg::ST_WAIT_OPEN:
          if (breaker_fail)
            state <= arsq_pkg::ST_LOCKOUT;
          else if (breaker_open && !act_trip)
          begin
            state       <= arsq_pkg::ST_DEAD;
            timer_start <= 1'b1;
            timer_steps <= dead_t[act_ch][shot];
          end
        arsq_pkg::ST_DEAD:
          if (tmr_fire)
          begin
            state         <= arsq_pkg::ST_CLOSE_REQ;
            close_request <= 1'b1;
          end
        arsq_pkg::ST_CLOSE_REQ:
          // Breaker control may hold the close back while its conditions fail
          if (breaker_fail)
          begin
            state         <= arsq_pkg::ST_LOCKOUT;
            close_request <= 1'b0;
          end
          else if (breaker_closed)
          begin
            state         <= arsq_pkg::ST_SHOT_RECLAIM;
            close_request <= 1'b0;
            timer_start   <= 1'b1;
            timer_steps   <= recl_t[act_ch][shot];
          end
        arsq_pkg::ST_SHOT_RECLAIM:
          if (act_rise && nxt_found)
          begin
            state       <= arsq_pkg::ST_WAIT_OPEN;
            shot        <= nxt_idx;
            shot_active <= 5'h01 << nxt_idx;
          end
          else if (act_rise)
          begin
            state                <= arsq_pkg::ST_FINAL_TRIP;
            final_trip           <= 1'b1;
            reclose_cycle_active <= 1'b0;
            channel_pending      <= '0;
            shot_active          <= 5'h00;
          end
          else if (tmr_fire)
          begin
            reclose_cycle_active <= 1'b0;
            channel_pending      <= '0;
            shot_active          <= 5'h00;
            if (ctrl[arsq_pkg::CTRL_WIN_EN])
            begin
              state                  <= arsq_pkg::ST_GLOBAL_RECLAIM;
              global_recovery_window <= 1'b1;
              timer_start            <= 1'b1;
              timer_steps            <= grecl_t;
            end
            else
              state <= arsq_pkg::ST_READY;
          end
        arsq_pkg::ST_GLOBAL_RECLAIM:
          if (any_trip && ctrl[arsq_pkg::CTRL_FT_RET])
          begin
            state                  <= arsq_pkg::ST_FINAL_TRIP;
            final_trip             <= 1'b1;
            global_recovery_window <= 1'b0;
          end
          else if (any_trip || tmr_fire)
          begin
            // Without the option a returning fault simply starts a fresh cycle
            state                  <= arsq_pkg::ST_READY;
            global_recovery_window <= 1'b0;
          end
        arsq_pkg::ST_FINAL_TRIP:
        begin
          state                 <= arsq_pkg::ST_LOCKOUT;
          reclose_blocked_state <= 1'b1;
        end
        arsq_pkg::ST_LOCKOUT:
          if (lockout_reset || closed_rise)
          begin
            state                 <= arsq_pkg::ST_READY;
            reclose_blocked_state <= 1'b0;
          end
          else
          begin
            reclose_blocked_state <= 1'b1;
            close_request         <= 1'b0;
            reclose_cycle_active  <= 1'b0;
            channel_pending       <= '0;
            shot_active           <= 5'h00;
          end
        default:
          state <= arsq_pkg::ST_READY;
      endcase
    end

  // Events for the interrupt status
  assign irq_ev[arsq_pkg::IRQ_START]   = (state == arsq_pkg::ST_READY) && any_trip && nxt_found;
  assign irq_ev[arsq_pkg::IRQ_CLOSE]   = (state == arsq_pkg::ST_DEAD) && tmr_fire;
  assign irq_ev[arsq_pkg::IRQ_SUCCESS] = (state == arsq_pkg::ST_SHOT_RECLAIM) && !act_rise && tmr_fire;
  assign irq_ev[arsq_pkg::IRQ_LOCK]    = (state != arsq_pkg::ST_LOCKOUT) && (
                                         (state == arsq_pkg::ST_FINAL_TRIP) ||
                                         (breaker_fail && (state == arsq_pkg::ST_WAIT_OPEN ||
                                                           state == arsq_pkg::ST_CLOSE_REQ)));
  assign rd_clr = acc && !hwrite && (haddr[11:0] == arsq_pkg::ADDR_IRQ_STAT);

  // Sticky status, cleared by reading it; a same-cycle event survives
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end
    else
    begin
      irq_stat <= (rd_clr ? '0 : irq_stat) | irq_ev;
      irq      <= |(irq_stat & irq_mask);
    end

  // Register read mux, sampled in the address phase
  always_comb
  begin
    rd_val = 32'h0;
    if (haddr[11:6] >= arsq_pkg::CH_BASE_IDX && 32'(haddr[11:6]) < NUM_CH + 1)
    begin
      if (haddr[5:2] == arsq_pkg::WORD_ENABLE)
        rd_val = {27'h0, shot_en[CW'(haddr[11:6] - arsq_pkg::CH_BASE_IDX)]};
      else if (haddr[5:2] < arsq_pkg::WORD_RECL0)
        rd_val = {13'h0, dead_t[CW'(haddr[11:6] - arsq_pkg::CH_BASE_IDX)]
                              [3'(haddr[5:2] - arsq_pkg::WORD_DEAD0)]};
      else if (haddr[5:2] < arsq_pkg::WORD_RECL0 + 4'h5)
        rd_val = {13'h0, recl_t[CW'(haddr[11:6] - arsq_pkg::CH_BASE_IDX)]
                              [3'(haddr[5:2] - arsq_pkg::WORD_RECL0)]};
    end
    else
      case (haddr[11:0])
        arsq_pkg::ADDR_CTRL:     rd_val = {30'h0, ctrl};
        arsq_pkg::ADDR_GRECL:    rd_val = {13'h0, grecl_t};
        arsq_pkg::ADDR_STATUS:   rd_val = {16'h0, 5'(act_ch), shot, 5'h0, state};
        arsq_pkg::ADDR_IRQ_STAT: rd_val = {28'h0, irq_stat};
        arsq_pkg::ADDR_IRQ_MASK: rd_val = {28'h0, irq_mask};
        default:                 rd_val = 32'h0;
      endcase
  end

  // Zero-wait slave: read data registered for the data phase, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
      wr_pend   <= 1'b0;
      wr_addr   <= 12'h0;
    end
    else
    begin
      wr_pend <= acc && hwrite;
      if (acc)
        wr_addr <= haddr[11:0];
      if (acc && !hwrite)
        hrdata <= rd_val;
    end

  // Settings written in the data phase; times saturate at the top of range
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ctrl     <= arsq_pkg::CTRL_RST;
      grecl_t  <= arsq_pkg::GRECL_RST;
      irq_mask <= '0;
      for (int c = 0; c < NUM_CH; c++)
      begin
        shot_en[c] <= arsq_pkg::SHOT_EN_RST;
        for (int s = 0; s < 5; s++)
        begin
          dead_t[c][s] <= (s == 0) ? arsq_pkg::DEAD1_RST : arsq_pkg::DEADN_RST;
          recl_t[c][s] <= arsq_pkg::RECL_RST;
        end
      end
    end
    else if (wr_pend)
    begin
      if (wr_ch_ok)
      begin
        if (wr_word == arsq_pkg::WORD_ENABLE)
          shot_en[wr_ch] <= hwdata[4:0];
        else if (wr_word < arsq_pkg::WORD_RECL0)
          dead_t[wr_ch][3'(wr_word - arsq_pkg::WORD_DEAD0)] <=
            (hwdata[18:0] > arsq_pkg::MAX_STEPS) ? arsq_pkg::MAX_STEPS : hwdata[18:0];
        else if (wr_word < arsq_pkg::WORD_RECL0 + 4'h5)
          recl_t[wr_ch][3'(wr_word - arsq_pkg::WORD_RECL0)] <=
            (hwdata[18:0] > arsq_pkg::MAX_STEPS) ? arsq_pkg::MAX_STEPS : hwdata[18:0];
      end
      else if (wr_addr == arsq_pkg::ADDR_CTRL)
        ctrl <= hwdata[1:0];
      else if (wr_addr == arsq_pkg::ADDR_GRECL)
        grecl_t <= (hwdata[18:0] > arsq_pkg::MAX_STEPS) ? arsq_pkg::MAX_STEPS : hwdata[18:0];
      else if (wr_addr == arsq_pkg::ADDR_IRQ_MASK)
        irq_mask <= hwdata[3:0];
    end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_final_then_lock;
    final_trip && !reclose_cycle_active ##1 reclose_blocked_state;
  endsequence
  property p_start;
    state == arsq_pkg::ST_READY && any_trip && nxt_found |=>
      reclose_cycle_active && channel_pending != '0 && shot_active != 5'h00;
  endproperty
  a_start: assert property (p_start) else $error("cycle start flags missing");
  property p_dead_start;
    state == arsq_pkg::ST_WAIT_OPEN && !breaker_fail && breaker_open && !act_trip |=>
      state == arsq_pkg::ST_DEAD ##1 close_request == 1'b0;
  endproperty
  a_dead_start: assert property (p_dead_start) else $error("dead interval not started");
  property p_close_hold;
    state == arsq_pkg::ST_CLOSE_REQ && !breaker_closed && !breaker_fail |=> close_request;
  endproperty
  a_close_hold: assert property (p_close_hold) else $error("close request dropped early");
  property p_close_drop;
    state == arsq_pkg::ST_CLOSE_REQ && breaker_closed && !breaker_fail |=>
      !close_request && state == arsq_pkg::ST_SHOT_RECLAIM;
  endproperty
  a_close_drop: assert property (p_close_drop) else $error("close not dropped on closed");
  property p_advance;
    state == arsq_pkg::ST_SHOT_RECLAIM && act_rise && nxt_found |=>
      shot_active != $past(shot_active) && reclose_cycle_active;
  endproperty
  a_advance: assert property (p_advance) else $error("shot did not advance");
  property p_no_shot_left;
    state == arsq_pkg::ST_SHOT_RECLAIM && act_rise && !nxt_found |=> s_final_then_lock;
  endproperty
  a_no_shot_left: assert property (p_no_shot_left) else $error("final trip missing");
  property p_global_return;
    state == arsq_pkg::ST_GLOBAL_RECLAIM && any_trip && ctrl[arsq_pkg::CTRL_FT_RET] |=>
      s_final_then_lock;
  endproperty
  a_global_return: assert property (p_global_return) else $error("return in window not locked");
  property p_fail_lock;
    breaker_fail && (state == arsq_pkg::ST_WAIT_OPEN || state == arsq_pkg::ST_CLOSE_REQ) |=>
      ##1 reclose_blocked_state;
  endproperty
  a_fail_lock: assert property (p_fail_lock) else $error("failure did not lock out");
  property p_lock_hold;
    reclose_blocked_state && state == arsq_pkg::ST_LOCKOUT && !lockout_reset && !closed_rise |=>
      reclose_blocked_state;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock-out left without cause");
endmodule : arsq_sequencer

// [core/arsq_shot_find.sv]
`timescale 1ns/1ps
// Lowest enabled shot at or above a starting index
module arsq_shot_find (
  input  wire logic [4:0] shot_en,
  input  wire logic [2:0] from,
  output logic            found,
  output logic [2:0]      idx
);
  always_comb
  begin
    found = 1'b0;
    idx   = 3'h0;
    for (int i = 4; i >= 0; i--)
      if (shot_en[i] && (3'(i) >= from))
      begin
        found = 1'b1;
        idx   = 3'(i);
      end
  end
endmodule : arsq_shot_find

// [core/arsq_timer.sv]
`timescale 1ns/1ps
// Single interval timer on the 5 ms grid; a zero setting finishes at once
module arsq_timer #(
  parameter int unsigned TICK_CYCLES = arsq_pkg::TICK_CYCLES
) (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        start,
  input  wire logic [arsq_pkg::TIME_W-1:0] steps,
  output logic                             done
);
  logic [31:0]                 presc;
  logic [arsq_pkg::TIME_W-1:0] cnt;
  logic                        busy;
  logic                        tick;

  // A prescaler of one cycle could not restart cleanly with each interval
  if (TICK_CYCLES < 2)
  begin : g_bad_tick
    $error("TICK_CYCLES too small");
  end

  assign tick = (presc == TICK_CYCLES - 1);

  // Prescaler restarts with each interval so the first step is whole
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      presc <= 32'h0;
    else if (start || tick)
      presc <= 32'h0;
    else
      presc <= presc + 32'h1;

  // Countdown; zero setting raises done on the next edge
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cnt  <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        cnt  <= steps;
        busy <= (steps != '0);
        done <= (steps == '0);
      end
      else if (busy && tick)
      begin
        cnt <= cnt - 1'b1;
        if (cnt == 1)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_zero_bypass;
    start && steps == '0 |=> done;
  endproperty
  a_zero_bypass: assert property (p_zero_bypass) else $error("zero interval not bypassed");
endmodule : arsq_timer

// [sim/arsq_breaker_model.sv]
`timescale 1ns/1ps
// Breaker with its object control: opens on command, closes a little late, on request or by hand
module arsq_breaker_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic open_cmd,
  input  wire logic close_ok,
  input  wire logic close_request,
  input  wire logic manual_close,
  output logic      breaker_open,
  output logic      breaker_closed
);
  logic [1:0] close_cnt;

  // Coil driven on a request while closing conditions hold, or by hand regardless; travel takes a few cycles so the request must stand
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      breaker_closed <= 1'b1;
      close_cnt      <= 2'h0;
    end
    else if (open_cmd)
    begin
      breaker_closed <= 1'b0;
      close_cnt      <= 2'h0;
    end
    else if ((close_request && close_ok || manual_close) && !breaker_closed)
    begin
      close_cnt      <= close_cnt + 2'h1;
      breaker_closed <= (close_cnt == 2'h2);
    end
  end

  // Status contacts are complementary
  assign breaker_open = ~breaker_closed;
endmodule : arsq_breaker_model

// [sim/auto_reclose_sequencer_bench.sv]
`timescale 1ns/1ps
module auto_reclose_sequencer_bench;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, trip_request, channel_pending;
  logic [4:0]  shot_active;
  logic        close_request, reclose_cycle_active, global_recovery_window, final_trip;
  logic        reclose_blocked_state, breaker_open, breaker_closed, open_cmd, lockout_reset;
  logic        breaker_fail, manual_close;
  int          fail_count, checks;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  arsq_sequencer #(.NUM_CH(2), .TICK_CYCLES(4)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .trip_request(trip_request), .breaker_open(breaker_open), .breaker_closed(breaker_closed),
    .breaker_fail(breaker_fail), .lockout_reset(lockout_reset), .close_request(close_request),
    .reclose_cycle_active(reclose_cycle_active), .channel_pending(channel_pending),
    .shot_active(shot_active), .global_recovery_window(global_recovery_window),
    .final_trip(final_trip), .reclose_blocked_state(reclose_blocked_state), .irq(irq));

  arsq_breaker_model i_breaker (
    .hclk(hclk), .hresetn(hresetn), .open_cmd(open_cmd), .close_ok(1'b1), .close_request(close_request),
    .manual_close(manual_close), .breaker_open(breaker_open), .breaker_closed(breaker_closed));

  // Clock, 4 ns period
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic print_verdict;
    $display("fail_count=%0d checks=%0d", fail_count, checks);
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One single AHB transfer; reads are compared against exp
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    chk("hresp", 0, hresp);
    if (!w)
      chk("hrdata", exp, hrdata);
  endtask : ahb

  // Bounded wait; a timeout shows up as a mismatch
  task automatic wait_on(ref logic s, input logic v);
    int i;
    i = 0;
    while (s !== v && i < 500)
    begin
      @(posedge hclk);
      #1;
      i++;
    end
    chk("wait", v, s);
  endtask : wait_on

  // Protection trips on channel 1 and opens the breaker, then releases both four clock edges later
  task automatic trip(input logic [4:0] exp_shot);
    trip_request <= 2'h2;
    open_cmd     <= 1'b1;
    @(posedge hclk);
    #1;
    chk("shot_active", exp_shot, shot_active);
    chk("channel_pending", (exp_shot != 0) ? 2 : 0, channel_pending);
    chk("cycle_active", exp_shot != 0, reclose_cycle_active);
    chk("final_trip", exp_shot == 0, final_trip);
    repeat (3) @(posedge hclk);
    trip_request <= 2'h0;
    open_cmd     <= 1'b0;
  endtask : trip

  task automatic close_cyc;
    wait_on(close_request, 1'b1);
    wait_on(breaker_closed, 1'b1);
    chk("close_request", 1, close_request);
    @(posedge hclk);
    #1;
    chk("close_request", 0, close_request);
  endtask : close_cyc

  task automatic lock_clear;
    chk("blocked", 1, reclose_blocked_state);
    lockout_reset <= 1'b1;
    @(posedge hclk);
    lockout_reset <= 1'b0;
    #1;
    chk("blocked", 0, reclose_blocked_state);
  endtask : lock_clear

  task automatic t_regs;
    ahb(0, 12'h040, 0, 32'h3);
    ahb(0, 12'h004, 0, 32'h7d0);
    ahb(0, 12'h000, 0, 32'h1);
    ahb(0, 12'h200, 0, 32'h0);
    ahb(1, 12'h094, 32'hfffff, 0);
    ahb(0, 12'h094, 0, 32'h57e40);
    ahb(1, 12'h084, 32'h0, 0);
    ahb(1, 12'h088, 32'h3, 0);
    ahb(1, 12'h098, 32'h6, 0);
    ahb(1, 12'h09c, 32'h6, 0);
    ahb(1, 12'h004, 32'h5, 0);
    ahb(1, 12'h010, 32'hf, 0);
  endtask : t_regs

  task automatic t_two_shots;
    trip(5'h01);
    close_cyc;
    trip(5'h02);
    close_cyc;
    wait_on(reclose_cycle_active, 1'b0);
    chk("window", 1, global_recovery_window);
    chk("shot_active", 0, shot_active);
    chk("irq", 1, irq);
    ahb(0, 12'h00c, 0, 32'h7);
    wait_on(global_recovery_window, 1'b0);
    chk("irq", 0, irq);
  endtask : t_two_shots

  task automatic t_lockout;
    trip(5'h01);
    close_cyc;
    trip(5'h02);
    close_cyc;
    trip(5'h00);
    lock_clear;
  endtask : t_lockout

  task automatic t_window;
    ahb(1, 12'h000, 32'h3, 0);
    trip(5'h01);
    close_cyc;
    wait_on(global_recovery_window, 1'b1);
    trip(5'h00);
    lock_clear;
  endtask : t_window

  // Window off, then a failed open that a manual breaker closing releases
  task automatic t_options;
    ahb(1, 12'h000, 32'h0, 0);
    ahb(0, 12'h00c, 0, 32'hf);
    trip(5'h01);
    close_cyc;
    wait_on(reclose_cycle_active, 1'b0);
    chk("window", 0, global_recovery_window);
    ahb(0, 12'h008, 0, 32'h800);
    ahb(0, 12'h00c, 0, 32'h7);
    breaker_fail <= 1'b1;
    trip(5'h01);
    breaker_fail <= 1'b0;
    manual_close <= 1'b1;
    wait_on(breaker_closed, 1'b1);
    manual_close <= 1'b0;
    chk("blocked", 1, reclose_blocked_state);
    chk("cycle_active", 0, reclose_cycle_active);
    @(posedge hclk);
    #1;
    chk("blocked", 0, reclose_blocked_state);
    ahb(0, 12'h00c, 0, 32'h9);
  endtask : t_options

  // Main sequence
  initial
  begin
    {hresetn, hsel, hwrite, open_cmd, lockout_reset, breaker_fail, manual_close} = 7'h0;
    {haddr, hwdata, htrans, trip_request} = 68'h0;
    fail_count = 0;
    checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_two_shots;
    t_lockout;
    t_window;
    t_options;
    print_verdict;
  end

  // Whole run needs a few hundred cycles; this limit of 25000 cycles is generous
  initial
  begin
    #100000;
    fail_count++;
    print_verdict;
  end
endmodule : auto_reclose_sequencer_bench
